/* inc/p51_timing_map.svh */
// Timing constants, field positions and reset values of the instruction timing block
// Contract
// - No instruction takes more than eight clock cycles.
// - A taken conditional branch costs exactly one cycle more than not taken.
// - Most instructions spend as many cycles as they have program bytes.
// - Timing counts plain clock cycles, never multi-clock machine cycles.
// - Opcodes keep standard 8051 encoding, addressing, function and flag effects.
// - Data-move writes reach on-chip data RAM or on-chip program flash.
// - No off-chip bus cycles; every access stays on chip.
// - Software reads and writes program flash one byte per access.
// - Accumulator or register arithmetic, inc, dec, pointer increment: one byte, one cycle.
// - Direct-address arithmetic, inc and dec: two bytes, two cycles.
// - Register-indirect arithmetic, inc and dec: one byte, two cycles.
// - Immediate add, add with carry, subtract with borrow: two bytes, two cycles.
// - 109 instructions; one instruction per clock sustained at peak.
// - Debug offers breakpoints, halt, resume, single step, also inside interrupt handlers.
// - Debug uses no user RAM, stack, timers or other user resources.
// - External-data moves via either pointer: one byte, three cycles.
// - Bit-test jump: three bytes, three cycles not taken, four taken.
`ifndef P51_TIMING_MAP_SVH
`define P51_TIMING_MAP_SVH
`define P51_CLK_PERIOD_NS 50
`define P51_MAX_CYCLES 4'h8
`define P51_ACC_CYCLE 4'h2
`define P51_EXT_MOVE_CYCLES 4'h3
`define P51_BIT_JUMP_BYTES 2'h3
`define P51_BIT_JUMP_CYCLES 4'h3
`define P51_OP_HI 7:4
`define P51_OP_LO 3:0
`define P51_LEFT_RST 4'h0
`endif

/* inc/p51_pkg.sv */
// Types shared by the instruction timing block
package p51_pkg;
  typedef enum logic [1:0] {
    P51_ACC_NONE = 2'b00,
    P51_ACC_XREAD = 2'b01,
    P51_ACC_XWRITE = 2'b10,
    P51_ACC_CODE = 2'b11
  } p51_acc_t;

  typedef enum logic [1:0] {
    P51_DBG_RUN = 2'b00,
    P51_DBG_HALT = 2'b01,
    P51_DBG_STEP = 2'b10
  } p51_dbg_mode_t;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cycles;
    logic condBranch;
    p51_acc_t acc;
  } p51_dec_t;

  typedef struct packed {
    p51_dbg_mode_t mode;
    logic skipBp;
  } p51_dbg_st_t;

  typedef struct packed {
    p51_dec_t dec;
    logic [7:0] opc;
    logic [3:0] left;
    logic [3:0] cnt;
    logic opTake;
    logic fetchReq;
    logic instrDone;
    logic takenExtra;
    logic busy;
    logic ramWe;
    logic ramRe;
    logic flashWe;
    logic flashRe;
    logic flashSel;
    logic [15:0] memAddr;
    logic [7:0] memWrData;
    logic halted;
  } p51_core_st_t;
endpackage

/* rtl/p51_op_decoder.sv */
// Opcode to byte length, base cycle count and access class decoder
`timescale 1ns/1ns
`include "p51_timing_map.svh"
module p51_op_decoder (
  // Opcode in
  input wire logic [7:0] opcode,
  // Decoded timing
  output p51_pkg::p51_dec_t dec
);
  import p51_pkg::*;

  logic [3:0] hi;
  logic [3:0] lo;

  assign hi = opcode[`P51_OP_HI];
  assign lo = opcode[`P51_OP_LO];

  function automatic p51_dec_t mk(input logic [1:0] l, input logic [3:0] c, input logic b);
    mk = '{len: l, cycles: c, condBranch: b, acc: P51_ACC_NONE};
  endfunction

  // Standard column layout of the 8051 map; cycles are the not-taken figure
  always_comb begin
    dec = mk(2'h1, 4'h1, 1'b0);
    if (lo >= 4'h8) begin
      case (hi)
        4'h7, 4'h8, 4'ha: dec = mk(2'h2, 4'h2, 1'b0);
        4'hb: dec = mk(2'h3, 4'h3, 1'b1);
        4'hd: dec = mk(2'h2, 4'h2, 1'b1);
        default: dec = mk(2'h1, 4'h1, 1'b0);
      endcase
    end else if (lo >= 4'h6) begin
      case (hi)
        4'h7, 4'h8, 4'ha: dec = mk(2'h2, 4'h2, 1'b0);
        4'hb: dec = mk(2'h3, 4'h4, 1'b1);
        default: dec = mk(2'h1, 4'h2, 1'b0);
      endcase
    end else begin
      case (lo)
        4'h0: begin
          case (hi)
            4'h0: dec = mk(2'h1, 4'h1, 1'b0);
            4'h1, 4'h2, 4'h3: dec = mk(2'h3, 4'h3, 1'b1);
            4'h4, 4'h5, 4'h6, 4'h7: dec = mk(2'h2, 4'h2, 1'b1);
            4'h8: dec = mk(2'h2, 4'h3, 1'b0);
            4'h9: dec = mk(2'h3, 4'h3, 1'b0);
            4'he, 4'hf: dec = mk(2'h1, 4'h3, 1'b0);
            default: dec = mk(2'h2, 4'h2, 1'b0);
          endcase
        end
        4'h1: dec = mk(2'h2, 4'h3, 1'b0);
        4'h2: begin
          case (hi)
            4'h0, 4'h1: dec = mk(2'h3, 4'h4, 1'b0);
            4'h2, 4'h3: dec = mk(2'h1, 4'h5, 1'b0);
            4'he, 4'hf: dec = mk(2'h1, 4'h3, 1'b0);
            default: dec = mk(2'h2, 4'h2, 1'b0);
          endcase
        end
        4'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: dec = mk(2'h3, 4'h3, 1'b0);
            4'h7, 4'h8, 4'h9, 4'he, 4'hf: dec = mk(2'h1, 4'h3, 1'b0);
            default: dec = mk(2'h1, 4'h1, 1'b0);
          endcase
        end
        4'h4: begin
          case (hi)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: dec = mk(2'h2, 4'h2, 1'b0);
            4'h8: dec = mk(2'h1, 4'h8, 1'b0);
            4'ha: dec = mk(2'h1, 4'h4, 1'b0);
            4'hb: dec = mk(2'h3, 4'h3, 1'b1);
            default: dec = mk(2'h1, 4'h1, 1'b0);
          endcase
        end
        default: begin
          case (hi)
            4'h7, 4'h8: dec = mk(2'h3, 4'h3, 1'b0);
            4'ha: dec = mk(2'h1, 4'h1, 1'b0);
            4'hb, 4'hd: dec = mk(2'h3, 4'h3, 1'b1);
            default: dec = mk(2'h2, 4'h2, 1'b0);
          endcase
        end
      endcase
    end
    if (lo == 4'h0 || lo == 4'h2 || lo == 4'h3) begin
      if (hi == 4'he) begin
        dec.acc = P51_ACC_XREAD;
      end else if (hi == 4'hf) begin
        dec.acc = P51_ACC_XWRITE;
      end
    end
    if (opcode == 8'h83 || opcode == 8'h93) begin
      dec.acc = P51_ACC_CODE;
    end
  end
endmodule

/* rtl/p51_debug_ctl.sv */
// Breakpoint, halt, resume and single-step control
`timescale 1ns/1ns
module p51_debug_ctl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // Debug requests
  input wire logic bpEnable,
  input wire logic [15:0] bpAddr,
  input wire logic haltReq,
  input wire logic runReq,
  input wire logic stepReq,
  // Offer from fetch
  input wire logic opValid,
  input wire logic [15:0] opPc,
  input wire logic seqFree,
  // Issue gating
  output logic issueAllow,
  output logic allowNext,
  output logic haltedNext
);
  import p51_pkg::*;

  p51_dbg_st_t r;
  p51_dbg_st_t n;
  logic bpHit;
  logic issue;

  // Only private flops here, so debugging never disturbs user state
  always_comb begin
    bpHit = bpEnable && opValid && (opPc == bpAddr) && !r.skipBp;
    issueAllow = (r.mode != P51_DBG_HALT) && !bpHit;
    issue = seqFree && opValid && issueAllow;
    n = r;
    unique case (r.mode)
      P51_DBG_RUN: begin
        if (haltReq || (seqFree && bpHit)) begin
          n.mode = P51_DBG_HALT;
        end
      end
      P51_DBG_STEP: begin
        if (haltReq || issue) begin
          n.mode = P51_DBG_HALT;
        end
      end
      P51_DBG_HALT: begin
        if (stepReq) begin
          n.mode = P51_DBG_STEP;
          n.skipBp = 1'b1;
        end else if (runReq) begin
          n.mode = P51_DBG_RUN;
          n.skipBp = 1'b1;
        end
      end
      default: n.mode = P51_DBG_HALT;
    endcase
    if (issue) begin
      n.skipBp = 1'b0;
    end
    allowNext = n.mode != P51_DBG_HALT;
    haltedNext = n.mode == P51_DBG_HALT;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '{mode: P51_DBG_RUN, skipBp: 1'b0};
    end else if (clkEn) begin
      r <= n;
    end
  end
endmodule

/* rtl/p51_timing_core.sv */
// Instruction sequencer: timing, on-chip memory strobes and debug gating
`timescale 1ns/1ns
`include "p51_timing_map.svh"
module p51_timing_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // Instruction offer
  input wire logic opValid,
  input wire logic [7:0] opcode,
  input wire logic [15:0] opPc,
  input wire logic branchCond,
  output logic fetchReq,
  output logic opTake,
  // Data move operands
  input wire logic [15:0] dataAddr,
  input wire logic [7:0] dataWrData,
  input wire logic flashWriteSel,
  // On-chip memory strobes
  output logic ramWe,
  output logic ramRe,
  output logic flashWe,
  output logic flashRe,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  // Timing report
  output logic [1:0] instrLen,
  output logic [3:0] baseCycles,
  output logic takenExtra,
  output logic instrDone,
  output logic busy,
  output logic [3:0] doneCycles,
  // Debug
  input wire logic bpEnable,
  input wire logic [15:0] bpAddr,
  input wire logic haltReq,
  input wire logic runReq,
  input wire logic stepReq,
  output logic halted
);
  import p51_pkg::*;

  p51_core_st_t r;
  p51_core_st_t n;
  p51_dec_t decNew;
  logic seqFree;
  logic accept;
  logic issueAllow;
  logic allowNext;
  logic haltedNext;

  p51_op_decoder u_dec (
    .opcode(opcode),
    .dec(decNew)
  );

  p51_debug_ctl u_dbg (
    .core_clk(core_clk),
    .reset(reset),
    .clkEn(clkEn),
    .bpEnable(bpEnable),
    .bpAddr(bpAddr),
    .haltReq(haltReq),
    .runReq(runReq),
    .stepReq(stepReq),
    .opValid(opValid),
    .opPc(opPc),
    .seqFree(seqFree),
    .issueAllow(issueAllow),
    .allowNext(allowNext),
    .haltedNext(haltedNext)
  );

  // Free in the last cycle of an instruction, so one-cycle ops issue back to back
  assign seqFree = r.left == `P51_LEFT_RST;

  always_comb begin
    n = r;
    accept = seqFree && opValid && issueAllow;
    n.opTake = accept;
    n.ramWe = 1'b0;
    n.ramRe = 1'b0;
    n.flashWe = 1'b0;
    n.flashRe = 1'b0;
    if (accept) begin
      n.dec = decNew;
      n.opc = opcode;
      n.cnt = 4'h1;
      // Condition travels with the offer so the total is known at issue
      n.takenExtra = decNew.condBranch && branchCond;
      n.left = decNew.cycles + {3'h0, n.takenExtra} - 4'h1;
      n.memAddr = dataAddr;
      n.memWrData = dataWrData;
      n.flashSel = flashWriteSel;
    end else if (!seqFree) begin
      n.left = r.left - 4'h1;
      n.cnt = r.cnt + 4'h1;
    end
    n.busy = accept || !seqFree;
    n.instrDone = n.busy && (n.left == `P51_LEFT_RST);
    n.fetchReq = (n.left == `P51_LEFT_RST) && allowNext;
    // One strobe per access; nothing leaves the chip
    if (n.busy && n.cnt == `P51_ACC_CYCLE) begin
      case (n.dec.acc)
        P51_ACC_XREAD: n.ramRe = 1'b1;
        P51_ACC_XWRITE: begin
          n.flashWe = n.flashSel;
          n.ramWe = !n.flashSel;
        end
        P51_ACC_CODE: n.flashRe = 1'b1;
        default: n.ramRe = 1'b0;
      endcase
    end
    n.halted = haltedNext;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else if (clkEn) begin
      r <= n;
    end
  end

  assign fetchReq = r.fetchReq;
  assign opTake = r.opTake;
  assign ramWe = r.ramWe;
  assign ramRe = r.ramRe;
  assign flashWe = r.flashWe;
  assign flashRe = r.flashRe;
  assign memAddr = r.memAddr;
  assign memWrData = r.memWrData;
  assign instrLen = r.dec.len;
  assign baseCycles = r.dec.cycles;
  assign takenExtra = r.takenExtra;
  assign instrDone = r.instrDone;
  assign busy = r.busy;
  assign doneCycles = r.cnt;
  assign halted = r.halted;

  default clocking a_clk @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_cycle_bound: assert property (
    instrDone |-> (doneCycles >= 4'h1) && (doneCycles <= `P51_MAX_CYCLES))
    else $error("instruction ran past eight cycles");

  a_branch_extra: assert property (
    (instrDone && takenExtra) |-> (doneCycles == baseCycles + 4'h1))
    else $error("taken branch not exactly one cycle longer");

  a_plain_count: assert property (
    (instrDone && !takenExtra) |-> (doneCycles == baseCycles))
    else $error("cycle count differs from base figure");

  a_reg_forms: assert property (
    (instrDone && r.opc[3] && (r.opc[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9}))
    |-> (instrLen == 2'h1) && (doneCycles == 4'h1))
    else $error("register form not one byte one cycle");

  a_direct_forms: assert property (
    (instrDone && (r.opc[3:0] == 4'h5) && (r.opc[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9}))
    |-> (instrLen == 2'h2) && (doneCycles == 4'h2))
    else $error("direct form not two bytes two cycles");

  a_indirect_forms: assert property (
    (instrDone && (r.opc[3:1] == 3'h3) && (r.opc[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9}))
    |-> (instrLen == 2'h1) && (doneCycles == 4'h2))
    else $error("indirect form not one byte two cycles");

  a_imm_forms: assert property (
    (instrDone && (r.opc[3:0] == 4'h4) && (r.opc[7:4] inside {4'h2, 4'h3, 4'h9}))
    |-> (instrLen == 2'h2) && (doneCycles == 4'h2))
    else $error("immediate form not two bytes two cycles");

  a_ext_move: assert property (
    (instrDone && (r.dec.acc inside {P51_ACC_XREAD, P51_ACC_XWRITE}))
    |-> (instrLen == 2'h1) && (doneCycles == `P51_EXT_MOVE_CYCLES))
    else $error("external data move not one byte three cycles");

  a_bit_jump: assert property (
    (instrDone && (r.opc == 8'h20 || r.opc == 8'h30))
    |-> (instrLen == `P51_BIT_JUMP_BYTES) && (doneCycles == `P51_BIT_JUMP_CYCLES + {3'h0, takenExtra}))
    else $error("bit-test jump timing wrong");

  a_write_route: assert property (
    (ramWe || flashWe) |-> !(ramWe && flashWe) && (r.cnt == `P51_ACC_CYCLE)
      && (flashWe == r.flashSel))
    else $error("data-move write misrouted");

  a_halt_blocks: assert property (
    (halted && clkEn && !opTake) |=> !opTake)
    else $error("instruction issued while halted");

  a_back_to_back: assert property (
    (clkEn && instrDone && opValid && issueAllow) |=> opTake && (doneCycles == 4'h1))
    else $error("ready offer not taken at end of instruction");

  a_one_strobe: assert property (
    $onehot0({ramWe, ramRe, flashWe, flashRe}))
    else $error("more than one memory strobe");

  a_strobe_slot: assert property (
    (ramWe || ramRe || flashWe || flashRe)
    |-> busy && (doneCycles == `P51_ACC_CYCLE))
    else $error("memory strobe outside access cycle");

  a_ram_read: assert property (
    ramRe
    |-> (r.dec.acc == P51_ACC_XREAD))
    else $error("data RAM read without external read");

  a_code_read: assert property (
    flashRe
    |-> (r.dec.acc == P51_ACC_CODE))
    else $error("flash read without code read");

  a_flash_write: assert property (
    flashWe
    |-> (r.dec.acc == P51_ACC_XWRITE) && r.flashSel)
    else $error("flash write without routed data move");

  a_ram_write: assert property (
    ramWe
    |-> (r.dec.acc == P51_ACC_XWRITE) && !r.flashSel)
    else $error("data RAM write without routed data move");

  a_move_strobe: assert property (
    (clkEn && busy && (doneCycles == 4'h1) && (r.dec.acc != P51_ACC_NONE))
    |=> (ramWe || ramRe || flashWe || flashRe))
    else $error("data move made no access");

  a_take_start: assert property (
    opTake
    |-> busy && (doneCycles == 4'h1))
    else $error("taken instruction not in its first cycle");

  a_done_busy: assert property (
    instrDone
    |-> busy)
    else $error("done without an executing instruction");

  a_count_step: assert property (
    (clkEn && busy && !instrDone)
    |=> busy && !opTake && (doneCycles == $past(doneCycles) + 4'h1))
    else $error("cycle count did not advance by one");

  // Freeze must hold the count, or timing drifts against the clock
  a_freeze_hold: assert property (
    !clkEn
    |=> $stable(doneCycles) && $stable(busy) && $stable(halted))
    else $error("state moved while clock enable low");

  a_done_free: assert property (
    (clkEn && instrDone)
    |=> !busy || opTake)
    else $error("sequencer not free after last cycle");

  a_decode_sane: assert property (
    busy
    |-> (instrLen != 2'h0) && (baseCycles != 4'h0))
    else $error("zero length or cycle count decoded");

  a_taken_cond: assert property (
    takenExtra
    |-> r.dec.condBranch)
    else $error("extra cycle on a non-branch");

  a_left_bound: assert property (
    r.left < `P51_MAX_CYCLES)
    else $error("remaining cycles beyond limit");

  a_offer_hold: assert property (
    (clkEn && busy && !instrDone)
    |=> $stable(memAddr) && $stable(instrLen) && $stable(baseCycles))
    else $error("instruction report changed mid instruction");

  a_halt_req: assert property (
    (clkEn && haltReq && !stepReq && !runReq)
    |=> halted)
    else $error("halt request ignored");

  a_run_req: assert property (
    (clkEn && halted && runReq && !stepReq)
    |=> !halted)
    else $error("resume request ignored");

  a_step_once: assert property (
    (clkEn && (u_dbg.r.mode == P51_DBG_STEP) && opValid && seqFree)
    |=> halted && opTake)
    else $error("single step did not issue exactly one");

  a_bp_stops: assert property (
    (clkEn && !halted && bpEnable && opValid && (opPc == bpAddr) && !u_dbg.r.skipBp)
    |=> !opTake)
    else $error("instruction issued at breakpoint");

  a_fetch_halt: assert property (
    halted
    |-> !fetchReq)
    else $error("fetch requested while halted");

  a_halt_quiet: assert property (
    (halted && !busy)
    |-> !(ramWe || ramRe || flashWe || flashRe))
    else $error("memory touched while halted");

  // Halting never cuts an instruction short
  a_halt_finish: assert property (
    (clkEn && halted && busy && !instrDone)
    |=> busy)
    else $error("halt aborted an instruction");
endmodule

/* tb/p51_mem_model.sv */
// On-chip data RAM and program flash model behind the access strobes
`timescale 1ns/1ns
module p51_mem_model (
  // Clock
  input wire logic core_clk,
  // Access strobes
  input wire logic ramWe,
  input wire logic ramRe,
  input wire logic flashWe,
  input wire logic flashRe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData
);
  // Only the low address byte is kept; tests stay inside it
  logic [7:0] ramMem [256];
  logic [7:0] flashMem [256];
  int nReads = 0;
  // Every access lands here, none leaves the chip
  always @(posedge core_clk) begin
    if (ramWe === 1'b1) ramMem[memAddr[7:0]] <= memWrData;
    if (flashWe === 1'b1) flashMem[memAddr[7:0]] <= memWrData;
    if ((ramRe | flashRe) === 1'b1) nReads <= nReads + 1;
  end
endmodule

/* tb/p51_timing_core_tb.sv */
// Self-checking bench of the instruction timing core
`timescale 1ns/1ns
module p51_timing_core_tb;
  logic core_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, opValid = 1'b0, branchCond = 1'b0, flashWriteSel = 1'b0;
  logic [7:0] opcode = 8'h00, dataWrData = 8'h00;
  logic [15:0] opPc = 16'h0000, dataAddr = 16'h0000, bpAddr = 16'h0000;
  logic bpEnable = 1'b0, haltReq = 1'b0, runReq = 1'b0, stepReq = 1'b0;
  logic fetchReq, opTake, ramWe, ramRe, flashWe, flashRe, takenExtra, instrDone, busy, halted;
  logic [15:0] memAddr;
  logic [7:0] memWrData;
  logic [1:0] instrLen;
  logic [3:0] baseCycles, doneCycles, stb;
  int nMismatch = 0, checksDone = 0, at, k;
  // Opcode, bytes, cycles
  localparam logic [15:0] OPS [24] = '{16'h2811, 16'h0411, 16'h0811, 16'h1411, 16'h1811, 16'ha311,
    16'h2522, 16'h0522, 16'h1522, 16'h3522, 16'h9522,
    16'h2612, 16'h0612, 16'h1712, 16'h3712, 16'h9612,
    16'h2422, 16'h3422, 16'h9422,
    16'ha414, 16'h8418, 16'h9033, 16'h0011, 16'he411};
  localparam logic [15:0] BRS [4] = '{16'h4022, 16'h5022, 16'h2033, 16'h3033};
  // Opcode, flash select, strobe set {ramWe,ramRe,flashWe,flashRe}
  localparam logic [15:0] MVS [8] = '{16'hf012, 16'hf212, 16'hf008, 16'hf208, 16'he004, 16'he204,
    16'h9301, 16'h8301};

  p51_timing_core p51_timing_core_i (.core_clk(core_clk), .reset(reset), .clkEn(clkEn), .opValid(opValid),
    .opcode(opcode), .opPc(opPc), .branchCond(branchCond), .fetchReq(fetchReq), .opTake(opTake),
    .dataAddr(dataAddr), .dataWrData(dataWrData), .flashWriteSel(flashWriteSel), .ramWe(ramWe), .ramRe(ramRe),
    .flashWe(flashWe), .flashRe(flashRe), .memAddr(memAddr), .memWrData(memWrData), .instrLen(instrLen),
    .baseCycles(baseCycles), .takenExtra(takenExtra), .instrDone(instrDone), .busy(busy),
    .doneCycles(doneCycles), .bpEnable(bpEnable), .bpAddr(bpAddr), .haltReq(haltReq), .runReq(runReq),
    .stepReq(stepReq), .halted(halted));
  p51_mem_model p51_mem_model_i (.core_clk(core_clk), .ramWe(ramWe), .ramRe(ramRe), .flashWe(flashWe),
    .flashRe(flashRe), .memAddr(memAddr), .memWrData(memWrData));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic completeRun();
    if (nMismatch == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One offer, then follow it to its last cycle
  task automatic run_op(input logic [15:0] spec, input logic cond, input logic ext, input logic [15:0] addr,
    input logic [7:0] wd, input logic fsel);
    int n;
    logic [3:0] total;
    n = 1;
    total = spec[3:0] + 4'(ext);
    stb = 4'h0;
    at = 0;
    @(posedge core_clk);
    opValid <= 1'b1;
    opcode <= spec[15:8];
    branchCond <= cond;
    dataAddr <= addr;
    dataWrData <= wd;
    flashWriteSel <= fsel;
    @(posedge core_clk);
    opValid <= 1'b0;
    #1;
    check(opTake, 1'b1, "offer not taken");
    check(busy, 1'b1, "not busy");
    check(instrLen, spec[7:4], "length");
    check(baseCycles, spec[3:0], "base cycles");
    check(takenExtra, ext, "taken flag");
    while (n < 12) begin
      if ({ramWe, ramRe, flashWe, flashRe} !== 4'h0) begin
        stb = stb | {ramWe, ramRe, flashWe, flashRe};
        at = n;
        check(memAddr, addr, "access address");
        check(memWrData, wd, "access data");
      end
      if (instrDone === 1'b1) break;
      @(posedge core_clk);
      #1;
      n++;
    end
    check(16'(n), total, "cycles to done");
    check(doneCycles, total, "done cycle count");
  endtask

  task automatic s_table();
    foreach (OPS[i]) begin
      run_op(OPS[i], 1'b1, 1'b0, 16'h0010, 8'h00, 1'b0);
      check(stb, 4'h0, "stray access");
    end
  endtask

  task automatic s_branch();
    foreach (BRS[i]) begin
      run_op(BRS[i], 1'b0, 1'b0, 16'h0010, 8'h00, 1'b0);
      run_op(BRS[i], 1'b1, 1'b1, 16'h0010, 8'h00, 1'b0);
    end
  endtask

  task automatic s_moves();
    foreach (MVS[i]) begin
      run_op({MVS[i][15:8], 8'h13}, 1'b0, 1'b0, 16'h0040 + 16'(i), 8'hc0 + 8'(i), MVS[i][4]);
      check(stb, MVS[i][3:0], "access kind");
      check(16'(at), 16'h0002, "access cycle");
      @(posedge core_clk);
      if (MVS[i][3] === 1'b1) check(p51_mem_model_i.ramMem[8'h40 + 8'(i)], 8'hc0 + 8'(i), "ram byte");
      if (MVS[i][1] === 1'b1) check(p51_mem_model_i.flashMem[8'h40 + 8'(i)], 8'hc0 + 8'(i), "flash byte");
    end
    check(16'(p51_mem_model_i.nReads), 16'h0004, "read count");
  endtask

  task automatic s_peak();
    k = 0;
    @(posedge core_clk);
    opValid <= 1'b1;
    opcode <= 8'h28;
    branchCond <= 1'b0;
    repeat (5) begin
      @(posedge core_clk);
      #1;
      if (opTake === 1'b1) k++;
    end
    opValid <= 1'b0;
    check(16'(k), 16'h0005, "back to back issue");
    repeat (3) @(posedge core_clk);
  endtask

  // Enable low mid instruction: count must hold, then finish
  task automatic s_freeze();
    @(posedge core_clk);
    opValid <= 1'b1;
    opcode <= 8'h90;
    @(posedge core_clk);
    opValid <= 1'b0;
    clkEn <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check(doneCycles, 4'h1, "count while frozen");
    clkEn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(instrDone, 1'b1, "done after freeze");
  endtask

  task automatic pulse(input logic [2:0] hrs);
    @(posedge core_clk);
    {haltReq, runReq, stepReq} <= hrs;
    @(posedge core_clk);
    {haltReq, runReq, stepReq} <= 3'b000;
  endtask

  task automatic takes(input int n);
    k = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (opTake === 1'b1) k++;
    end
  endtask

  task automatic s_debug();
    pulse(3'b100);
    takes(2);
    check(halted, 1'b1, "halt");
    check(fetchReq, 1'b0, "fetch while halted");
    opPc <= 16'h0200;
    opcode <= 8'h00;
    opValid <= 1'b1;
    takes(4);
    check(16'(k), 16'h0000, "issue while halted");
    pulse(3'b001);
    takes(8);
    check(16'(k), 16'h0001, "single step");
    check(halted, 1'b1, "halt after step");
    pulse(3'b010);
    takes(2);
    check(halted, 1'b0, "resume");
    bpEnable <= 1'b1;
    bpAddr <= 16'h0300;
    opPc <= 16'h0300;
    opValid <= 1'b1;
    takes(4);
    check(16'(k), 16'h0000, "breakpoint issue");
    check(halted, 1'b1, "breakpoint halt");
    pulse(3'b010);
    takes(8);
    check(16'(k), 16'h0001, "resume past breakpoint");
    opValid <= 1'b0;
    bpEnable <= 1'b0;
    pulse(3'b010);
    takes(2);
    check(halted, 1'b0, "running again");
    check(fetchReq, 1'b1, "fetch after resume");
  endtask

  // Whole run is a few hundred cycles
  initial begin
    #2000000;
    nMismatch++;
    completeRun();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    s_table();
    s_branch();
    s_moves();
    s_peak();
    s_freeze();
    s_debug();
    completeRun();
  end
endmodule
